/* File: hdl/scm_top.sv */
// scm_top: segmented capture memory with register port and data register
`timescale 1ns/1ps
// Functional notes
// - Pre-arm offset of minus three or lower selects segmented layout.
// - Segment count is arm count rounded up to a power of two.
// - Segment capacity is total memory divided by segment count.
// - Non-volatile retention reserves four locations in every segment.
// - Circular buffer is trigger count padded to four, ending segment top.
// - Pre-arm readings wrap and overwrite until arm and post count finish.
// - Next write address kept per segment; readout starts after the wrap point.
// - Status word: bit 0 wrapped, bit 1 aborted, bits 31..2 counter.
// - Counter points at the next location to be written.
// - Aborted flag set only for a segment ended by user abort.
// - Only arm-count segments fill, from segment zero upward.
// - Real-time data read triggers a conversion and returns the converter input present at the read.
// - Post-measurement data read returns the next stored reading.
// - Data register delivers readings packed in SCM_MEM_BOTH32 feed; other feeds give one channel zero-extended.
// - Data register sits at byte offset 12.
// - Data transfers are disabled after reset until software enables.
// - Combined mode returns channel 2 high, channel 1 low.
module scm_top import scm_pkg::*; #(
  parameter int AW = SCM_MEM_AW
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // converter and arming
  input wire logic [15:0] adc_ch1_in,
  input wire logic [15:0] adc_ch2_in,
  input wire logic adc_valid_in,
  input wire logic arm_in,
  output logic conv_start_out,
  // interrupt
  output logic irq_out
);
  localparam int LW = AW + 1;
  localparam int PW = LW + 8;
  // shift of a segment index must stay positive and nv space must fit
  if (AW < 9 || AW > 29) begin : g_chk
    $error("scm_top: AW out of range");
  end
  typedef struct packed {
    scm_state_e st;
    logic xfer_en;
    logic nv_en;
    scm_feed_e feed;
    logic [7:0] arm;
    logic [LW-1:0] trig;
    logic [31:0] pre;
    logic [7:0] seg;
    logic [AW-1:0] cnt;
    logic wrap;
    logic [LW-1:0] post_left;
    logic [7:0] rd_seg;
    logic [AW-1:0] rd_ptr;
    logic [LW-1:0] rd_left;
    logic rd_load;
    logic rd_ch;
    logic [SCM_IRQ_W-1:0] istat;
    logic [SCM_IRQ_W-1:0] imask;
    logic [7:0] seg_sel;
    logic [31:0] rdata;
    logic conv;
  } scm_st_s;
  localparam scm_st_s RST_VAL = '{
    st: SCM_IDLE,
    feed: SCM_MEM_CH1,
    arm: SCM_ARM_RST,
    trig: LW'(SCM_TRIG_RST),
    pre: SCM_PRE_RST,
    default: '0
  };
  scm_st_s q;
  scm_st_s n;
  scm_store_if #(.AW(AW)) sif ();
  scm_store #(.AW(AW)) u_store (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .s(sif)
  );
  function automatic logic [2:0] f_lg(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h7;
    for (int i = 6; i >= 0; i--) begin
      if ({1'b0, a} <= (9'h001 << i)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : f_lg
  function automatic logic [AW-1:0] f_base(input logic [7:0] s,
                                           input logic [4:0] sh);
    return AW'(s) << sh;
  endfunction : f_base
  // geometry
  logic seg_mode;
  logic [LW-1:0] pre_mag;
  logic [2:0] lg;
  logic [4:0] shift;
  logic [LW-1:0] segsz;
  logic [LW-1:0] cap;
  logic [LW-1:0] len;
  logic [PW-1:0] prod;
  logic [PW-1:0] lenu;
  logic [PW-1:0] lenw;
  logic [AW-1:0] foff;
  logic [LW-1:0] post_init;
  logic [LW-1:0] rd_total;
  logic [7:0] nused;
  logic cfg_bad;
  logic [AW-1:0] cur_first;
  logic [AW-1:0] cur_end;
  logic [AW-1:0] nxt_first;
  logic [AW-1:0] rd_first;
  logic [AW-1:0] rd_end;
  logic [AW-1:0] rd_start;
  logic [AW-1:0] rd_diff;
  always_comb begin
    seg_mode = $signed(q.pre) <= SCM_SEG_THR;
    pre_mag = seg_mode ? LW'(-q.pre) : '0;
    lg = seg_mode ? f_lg(q.arm) : 3'h0;
    shift = 5'(AW) - 5'(lg);
    segsz = LW'(1) << shift;
    cap = segsz - (q.nv_en ? LW'(SCM_NV_RSV) : LW'(0));
    prod = PW'(q.arm) * PW'(q.trig);
    lenu = seg_mode ? PW'(q.trig) : prod;
    lenw = (lenu + PW'(SCM_PAD - 1)) & ~PW'(SCM_PAD - 1);
    len = LW'(lenw);
    cfg_bad = q.arm == 8'h00 || q.arm > 8'(SCM_MAX_SEG) ||
              q.trig == '0 || lenw > PW'(cap);
    foff = AW'(segsz - len);
    if (!seg_mode) begin
      post_init = LW'(prod);
    end else if (pre_mag < q.trig) begin
      post_init = q.trig - pre_mag;
    end else begin
      post_init = '0;
    end
    rd_total = seg_mode ? q.trig : LW'(prod);
    nused = seg_mode ? q.arm : 8'h01;
    cur_first = f_base(q.seg, shift) + foff;
    cur_end = f_base(q.seg, shift) + AW'(segsz - LW'(1));
    nxt_first = f_base(q.seg + 8'h01, shift) + foff;
    rd_first = f_base(q.rd_seg, shift) + foff;
    rd_end = f_base(q.rd_seg, shift) + AW'(segsz - LW'(1));
  end
  // oldest wanted reading: newest trig readings end at counter minus one
  always_comb begin
    rd_diff = sif.tab_rcnt - rd_first;
    if (!seg_mode || !sif.tab_rwrap) begin
      rd_start = rd_first;
    end else if (LW'(rd_diff) >= q.trig) begin
      rd_start = sif.tab_rcnt - AW'(q.trig);
    end else begin
      rd_start = sif.tab_rcnt - AW'(q.trig) + AW'(len);
    end
  end
  logic start_w;
  logic abort_w;
  logic smp;
  logic fin;
  logic adv;
  logic at_end;
  logic [AW-1:0] ptr;
  logic [LW-1:0] left;
  logic [SCM_IRQ_W-1:0] ev;
  assign at_end = q.cnt == cur_end;
  assign sif.clr_shift = shift;
  assign sif.clr_off = foff;
  // a status query wins the table read port; strobes never coincide
  assign sif.tab_ridx = (rd_in && addr_in == SCM_OFF_SEGSTAT) ? q.seg_sel :
                        (q.rd_load ? q.rd_seg : q.seg_sel);
  always_comb begin
    n = q;
    n.rdata = '0;
    n.conv = 1'b0;
    start_w = 1'b0;
    abort_w = 1'b0;
    smp = 1'b0;
    fin = 1'b0;
    adv = 1'b0;
    ptr = q.rd_ptr;
    left = q.rd_left;
    ev = '0;
    sif.mem_we = 1'b0;
    sif.mem_waddr = q.cnt;
    sif.mem_wdata = {adc_ch2_in, adc_ch1_in};
    sif.mem_raddr = q.rd_ptr;
    sif.tab_we = 1'b0;
    sif.tab_widx = q.seg;
    sif.tab_wcnt = at_end ? cur_first : q.cnt + AW'(1);
    sif.tab_wwrap = q.wrap | at_end;
    sif.tab_wabt = 1'b0;
    sif.tab_clr = 1'b0;

    if (wr_in) begin
      case (addr_in)
        SCM_OFF_CTRL: begin
          n.xfer_en = wdata_in[SCM_CTL_EN];
          n.nv_en = wdata_in[SCM_CTL_NV];
          n.feed = scm_feed_e'(wdata_in[SCM_CTL_FEED +: 3]);
          start_w = wdata_in[SCM_CTL_START];
          abort_w = wdata_in[SCM_CTL_ABORT];
        end
        SCM_OFF_ARM: n.arm = wdata_in[7:0];
        SCM_OFF_TRIG: n.trig = wdata_in[LW-1:0];
        SCM_OFF_PRE: n.pre = wdata_in;
        SCM_OFF_ISTAT: n.istat = q.istat & ~wdata_in[SCM_IRQ_W-1:0];
        SCM_OFF_IMASK: n.imask = wdata_in[SCM_IRQ_W-1:0];
        SCM_OFF_SEGSEL: n.seg_sel = wdata_in[7:0];
        default: ;
      endcase
    end

    unique case (q.st)
      SCM_IDLE, SCM_DONE: ;
      SCM_PRE, SCM_POST: begin
        if (abort_w) begin
          sif.tab_we = 1'b1;
          sif.tab_wcnt = q.cnt;
          sif.tab_wwrap = q.wrap;
          sif.tab_wabt = 1'b1;
          n.st = SCM_DONE;
          ev[SCM_IRQ_ABT] = 1'b1;
          n.rd_seg = 8'h00;
          n.rd_load = 1'b1;
          n.rd_left = '0;
          n.rd_ch = 1'b0;
        end else begin
          smp = adc_valid_in;
          if (smp) begin
            // keep circling the buffer, older readings are lost
            sif.mem_we = 1'b1;
            sif.tab_we = 1'b1;
            n.cnt = sif.tab_wcnt;
            n.wrap = sif.tab_wwrap;
          end
          // a reading beside the arm still counts as pre-arm
          if (q.st == SCM_PRE && arm_in) begin
            n.st = SCM_POST;
            n.post_left = post_init;
          end
          if (q.st == SCM_POST) begin
            if (smp && q.post_left != '0) begin
              n.post_left = q.post_left - LW'(1);
            end
            fin = q.post_left == '0 || (smp && q.post_left == LW'(1));
          end
          if (fin) begin
            ev[SCM_IRQ_SEG] = 1'b1;
            if (q.seg + 8'h01 >= nused) begin
              n.st = SCM_DONE;
              ev[SCM_IRQ_DONE] = 1'b1;
              n.rd_seg = 8'h00;
              n.rd_load = 1'b1;
              n.rd_left = '0;
              n.rd_ch = 1'b0;
            end else begin
              n.st = SCM_PRE;
              n.seg = q.seg + 8'h01;
              n.cnt = nxt_first;
              n.wrap = 1'b0;
            end
          end
        end
      end
    endcase

    // start wins over the state and pointers the sequence set this cycle; its events still post
    if (start_w && !cfg_bad) begin
      n.st = SCM_PRE;
      n.seg = 8'h00;
      n.cnt = foff;
      n.wrap = 1'b0;
      n.post_left = '0;
      n.rd_seg = 8'h00;
      n.rd_load = 1'b0;
      n.rd_left = '0;
      n.rd_ch = 1'b0;
      sif.tab_clr = 1'b1;
    end

    if (rd_in) begin
      case (addr_in)
        SCM_OFF_CTRL: begin
          n.rdata[SCM_CTL_EN] = q.xfer_en;
          n.rdata[SCM_CTL_NV] = q.nv_en;
          n.rdata[SCM_CTL_FEED +: 3] = q.feed;
        end
        SCM_OFF_ARM: n.rdata = 32'(q.arm);
        SCM_OFF_TRIG: n.rdata = 32'(q.trig);
        SCM_OFF_PRE: n.rdata = q.pre;
        SCM_OFF_ISTAT: n.rdata = 32'(q.istat);
        SCM_OFF_IMASK: n.rdata = 32'(q.imask);
        SCM_OFF_SEGSEL: n.rdata = 32'(q.seg_sel);
        SCM_OFF_SEGSTAT: begin
          n.rdata = 32'(sif.tab_rcnt) << SCM_SW_CNT;
          n.rdata[SCM_SW_ABT] = sif.tab_rabt;
          n.rdata[SCM_SW_WRAP] = sif.tab_rwrap;
        end
        SCM_OFF_STATE: n.rdata = 32'({lg, cfg_bad, seg_mode, q.seg, q.st});
        SCM_OFF_DATA: begin
          // disabled transfers read zero and touch no pointer
          if (!q.xfer_en) begin
            n.rdata = '0;
          end else if (q.feed == SCM_CONV_CH1 || q.feed == SCM_CONV_CH2) begin
            n.conv = 1'b1;
            n.rdata = {16'h0000, q.feed == SCM_CONV_CH2 ?
                       adc_ch2_in : adc_ch1_in};
          end else if (q.st == SCM_DONE && (q.rd_load || q.rd_left != '0)) begin
            // loading and first pop share a cycle, so reads need no gap
            ptr = q.rd_load ? rd_start : q.rd_ptr;
            left = q.rd_load ? rd_total : q.rd_left;
            sif.mem_raddr = ptr;
            unique case (q.feed)
              SCM_MEM_CH1: n.rdata = {16'h0000, sif.mem_rdata[15:0]};
              SCM_MEM_CH2: n.rdata = {16'h0000, sif.mem_rdata[31:16]};
              SCM_MEM_BOTH: n.rdata = {16'h0000, q.rd_ch ?
                sif.mem_rdata[31:16] : sif.mem_rdata[15:0]};
              SCM_MEM_BOTH32: n.rdata = sif.mem_rdata;
              default: n.rdata = '0;
            endcase
            adv = q.feed != SCM_MEM_BOTH || q.rd_ch;
            n.rd_ch = q.feed == SCM_MEM_BOTH && !q.rd_ch;
            n.rd_load = 1'b0;
            n.rd_ptr = ptr;
            n.rd_left = left;
            if (adv) begin
              n.rd_ptr = (ptr == rd_end) ? rd_first : ptr + AW'(1);
              n.rd_left = left - LW'(1);
              if (left == LW'(1) && q.rd_seg + 8'h01 < nused) begin
                n.rd_seg = q.rd_seg + 8'h01;
                n.rd_load = 1'b1;
              end
            end
          end
        end
        default: n.rdata = '0;
      endcase
    end
    // a new event beats a clear in the same cycle
    n.istat = n.istat | ev;
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= RST_VAL;
    end else begin
      q <= n;
    end
  end

  assign rdata_out = q.rdata;
  assign conv_start_out = q.conv;
  assign irq_out = |(q.istat & q.imask);
endmodule : scm_top

/* File: hdl/scm_pkg.sv */
// scm_pkg: constants and types of the segmented capture memory
package scm_pkg;
  // memory geometry
  localparam int SCM_MEM_AW = 19;
  localparam int SCM_MAX_SEG = 128;
  localparam int SCM_SEG_IW = 7;
  localparam int SCM_NV_RSV = 4;
  localparam int SCM_PAD = 4;
  localparam int SCM_SEG_THR = -3;
  // register byte offsets
  localparam logic [7:0] SCM_OFF_CTRL = 8'h00;
  localparam logic [7:0] SCM_OFF_ARM = 8'h04;
  localparam logic [7:0] SCM_OFF_TRIG = 8'h08;
  localparam logic [7:0] SCM_OFF_DATA = 8'h0c;
  localparam logic [7:0] SCM_OFF_PRE = 8'h10;
  localparam logic [7:0] SCM_OFF_ISTAT = 8'h14;
  localparam logic [7:0] SCM_OFF_IMASK = 8'h18;
  localparam logic [7:0] SCM_OFF_SEGSEL = 8'h1c;
  localparam logic [7:0] SCM_OFF_SEGSTAT = 8'h20;
  localparam logic [7:0] SCM_OFF_STATE = 8'h24;
  // control register fields
  localparam int SCM_CTL_EN = 0;
  localparam int SCM_CTL_NV = 1;
  localparam int SCM_CTL_FEED = 2;
  localparam int SCM_CTL_START = 8;
  localparam int SCM_CTL_ABORT = 9;
  // interrupt status fields
  localparam int SCM_IRQ_W = 3;
  localparam int SCM_IRQ_DONE = 0;
  localparam int SCM_IRQ_SEG = 1;
  localparam int SCM_IRQ_ABT = 2;
  // segment status word fields
  localparam int SCM_SW_WRAP = 0;
  localparam int SCM_SW_ABT = 1;
  localparam int SCM_SW_CNT = 2;
  // reset values
  localparam logic [7:0] SCM_ARM_RST = 8'h01;
  localparam logic [31:0] SCM_TRIG_RST = 32'h0000_0004;
  localparam logic [31:0] SCM_PRE_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    SCM_MEM_CH1 = 3'b000,
    SCM_MEM_CH2 = 3'b001,
    SCM_MEM_BOTH = 3'b010,
    SCM_MEM_BOTH32 = 3'b011,
    SCM_CONV_CH1 = 3'b100,
    SCM_CONV_CH2 = 3'b101
  } scm_feed_e;
  typedef enum logic [1:0] {
    SCM_IDLE = 2'b00,
    SCM_PRE = 2'b01,
    SCM_POST = 2'b10,
    SCM_DONE = 2'b11
  } scm_state_e;
endpackage : scm_pkg

/* File: hdl/scm_store_if.sv */
// scm_store_if: path between control logic and capture storage
`timescale 1ns/1ps
interface scm_store_if #(parameter int AW = scm_pkg::SCM_MEM_AW);
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [AW-1:0] mem_raddr;
  logic [31:0] mem_rdata;
  logic tab_we;
  logic [7:0] tab_widx;
  logic [AW-1:0] tab_wcnt;
  logic tab_wwrap;
  logic tab_wabt;
  logic tab_clr;
  logic [4:0] clr_shift;
  logic [AW-1:0] clr_off;
  logic [7:0] tab_ridx;
  logic [AW-1:0] tab_rcnt;
  logic tab_rwrap;
  logic tab_rabt;
  modport ctrl (output mem_we, mem_waddr, mem_wdata, mem_raddr, tab_we,
    tab_widx, tab_wcnt, tab_wwrap, tab_wabt, tab_clr, clr_shift, clr_off,
    tab_ridx, input mem_rdata, tab_rcnt, tab_rwrap, tab_rabt);
  modport store (input mem_we, mem_waddr, mem_wdata, mem_raddr, tab_we,
    tab_widx, tab_wcnt, tab_wwrap, tab_wabt, tab_clr, clr_shift, clr_off,
    tab_ridx, output mem_rdata, tab_rcnt, tab_rwrap, tab_rabt);
endinterface : scm_store_if

/* File: hdl/scm_store.sv */
// scm_store: reading storage and per-segment status table
`timescale 1ns/1ps
module scm_store import scm_pkg::*; #(
  parameter int AW = SCM_MEM_AW
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // control side
  scm_store_if.store s
);
  logic [31:0] mem_q [2**AW];
  logic [AW-1:0] cnt_q [SCM_MAX_SEG];
  logic [SCM_MAX_SEG-1:0] wrap_q;
  logic [SCM_MAX_SEG-1:0] abt_q;

  // no reset on readings: too large to clear, a fill precedes any read
  always_ff @(posedge mclk_in) begin
    if (s.mem_we) begin
      mem_q[s.mem_waddr] <= s.mem_wdata;
    end
  end
  assign s.mem_rdata = mem_q[s.mem_raddr];

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < SCM_MAX_SEG; i++) begin
        cnt_q[i] <= '0;
      end
      wrap_q <= '0;
      abt_q <= '0;
    end else if (s.tab_clr) begin
      for (int i = 0; i < SCM_MAX_SEG; i++) begin
        cnt_q[i] <= (AW'(i) << s.clr_shift) + s.clr_off;
      end
      wrap_q <= '0;
      abt_q <= '0;
    end else if (s.tab_we) begin
      cnt_q[s.tab_widx[SCM_SEG_IW-1:0]] <= s.tab_wcnt;
      wrap_q[s.tab_widx[SCM_SEG_IW-1:0]] <= s.tab_wwrap;
      abt_q[s.tab_widx[SCM_SEG_IW-1:0]] <= s.tab_wabt;
    end
  end

  assign s.tab_rcnt = cnt_q[s.tab_ridx[SCM_SEG_IW-1:0]];
  assign s.tab_rwrap = wrap_q[s.tab_ridx[SCM_SEG_IW-1:0]];
  assign s.tab_rabt = abt_q[s.tab_ridx[SCM_SEG_IW-1:0]];
endmodule : scm_store

/* File: verification/scm_top_asserts.sv */
// scm_top_asserts: port-level checks of the capture memory
`timescale 1ns/1ps
module scm_top_asserts import scm_pkg::*; #(
  parameter int AW = SCM_MEM_AW
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // converter and arming
  input wire logic [15:0] adc_ch1_in,
  input wire logic [15:0] adc_ch2_in,
  input wire logic adc_valid_in,
  input wire logic arm_in,
  input wire logic conv_start_out,
  // interrupt
  input wire logic irq_out
);
  logic en_q;
  logic [2:0] feed_q;
  logic [2:0] imask_q;
  // shadow of control and mask, rebuilt from host writes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q <= 1'b0;
      feed_q <= 3'h0;
      imask_q <= 3'h0;
    end else if (wr_in && addr_in == SCM_OFF_CTRL) begin
      en_q <= wdata_in[SCM_CTL_EN];
      feed_q <= wdata_in[SCM_CTL_FEED+:3];
    end else if (wr_in && addr_in == SCM_OFF_IMASK) begin
      imask_q <= wdata_in[SCM_IRQ_W-1:0];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_data_rd;
    rd_in && addr_in == SCM_OFF_DATA;
  endsequence
  // feed codes 6 and 7 are undefined, so only 4 and 5 count as real time
  sequence s_rt_rd;
    s_data_rd ##0 (en_q && feed_q[2:1] == 2'b10);
  endsequence
  a_rdata_quiet: assert property (
    !rd_in |=> rdata_out == 32'h0) else $error("read data outside slot");
  a_conv_cause: assert property (
    conv_start_out |-> $past(rd_in && addr_in == SCM_OFF_DATA && en_q))
    else $error("conversion without data read");
  a_rt_conv: assert property (
    s_rt_rd |=> conv_start_out && rdata_out[31:16] == 16'h0)
    else $error("real-time read gave no conversion");
  a_rt_ch1: assert property (
    s_rt_rd ##0 !feed_q[0] |=> rdata_out[15:0] == $past(adc_ch1_in))
    else $error("real-time channel 1 value wrong");
  a_rt_ch2: assert property (
    s_rt_rd ##0 feed_q[0] |=> rdata_out[15:0] == $past(adc_ch2_in))
    else $error("real-time channel 2 value wrong");
  a_data_off: assert property (
    s_data_rd ##0 !en_q |=> rdata_out == 32'h0 && !conv_start_out)
    else $error("data read while transfers disabled");
  a_mem_noconv: assert property (
    s_data_rd ##0 !feed_q[2] |=> !conv_start_out)
    else $error("memory read started a conversion");
  a_irq_masked: assert property (
    imask_q == 3'h0 |-> !irq_out) else $error("irq with all masked");
endmodule : scm_top_asserts
bind scm_top scm_top_asserts #(.AW(AW)) u_asserts (
  .mclk_in(mclk_in),
  .arst_n_in(arst_n_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .adc_ch1_in(adc_ch1_in),
  .adc_ch2_in(adc_ch2_in),
  .adc_valid_in(adc_valid_in),
  .arm_in(arm_in),
  .conv_start_out(conv_start_out),
  .irq_out(irq_out)
);

/* File: verification/scm_conv_model.sv */
// scm_conv_model: converter and arm source facing the capture memory
`timescale 1ns/1ps
module scm_conv_model (
  // clock
  input wire logic mclk_in,
  // converter side
  output logic [15:0] ch1_out,
  output logic [15:0] ch2_out,
  output logic valid_out,
  output logic arm_out
);
  logic [15:0] idx = 16'h0;
  initial begin
    ch1_out = 16'h5a5a;
    ch2_out = 16'ha5a5;
    valid_out = 1'b0;
    arm_out = 1'b0;
  end
  // lines inverted after each pulse so stale data never matches
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      valid_out <= 1'b1;
      ch1_out <= 16'h0100 + idx;
      ch2_out <= 16'h0200 + idx;
      @(posedge mclk_in);
      valid_out <= 1'b0;
      ch1_out <= ~(16'h0100 + idx);
      ch2_out <= ~(16'h0200 + idx);
      idx = idx + 16'h1;
    end
  endtask : burst
  task automatic arm_ev();
    @(posedge mclk_in);
    arm_out <= 1'b1;
    @(posedge mclk_in);
    arm_out <= 1'b0;
  endtask : arm_ev
endmodule : scm_conv_model

/* File: verification/tb_segmented_capture_memory.sv */
// tb_segmented_capture_memory: self-checking bench of scm_top
`timescale 1ns/1ps
module tb_segmented_capture_memory import scm_pkg::*; ();
  localparam int AWS = 9;
  // last address of the single segment
  localparam logic [31:0] TOP = (32'h1 << AWS) - 32'h1;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] ch1;
  logic [15:0] ch2;
  logic vld;
  logic arm;
  logic cs;
  logic irq;
  logic [31:0] rv;
  logic rcs;
  int bad_count = 0;
  int checks = 0;
  logic [39:0] rows [11] = '{
    {8'h00, 32'h0}, {8'h04, 32'h1}, {8'h08, 32'h4}, {8'h0c, 32'h0},
    {8'h10, 32'h0}, {8'h14, 32'h0}, {8'h18, 32'h0}, {8'h1c, 32'h0},
    {8'h20, 32'h0}, {8'h24, 32'h0}, {8'h40, 32'h0}};
  always #25 mclk_in = ~mclk_in;
  scm_conv_model u_conv (.mclk_in(mclk_in), .ch1_out(ch1), .ch2_out(ch2),
    .valid_out(vld), .arm_out(arm));
  scm_top #(.AW(AWS)) DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .adc_ch1_in(ch1), .adc_ch2_in(ch2),
    .adc_valid_in(vld), .arm_in(arm), .conv_start_out(cs), .irq_out(irq));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // a leading edge keeps strobe drops and raises in separate steps
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    @(negedge mclk_in);
    rv = rdata;
    rcs = cs;
  endtask : rd_reg
  task automatic wait_irq();
    repeat (50) if (irq !== 1'b1) @(negedge mclk_in);
  endtask : wait_irq
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    foreach (rows[i]) begin
      rd_reg(rows[i][39:32]);
      chk("reset read", rows[i][31:0], rv);
      chk("reset conv", 32'h0, {31'h0, rcs});
    end
    wr_reg(SCM_OFF_CTRL, 32'h11);
    rd_reg(SCM_OFF_DATA);
    chk("rt ch1", 32'h5a5a, rv);
    chk("rt conv", 32'h1, {31'h0, rcs});
    wr_reg(SCM_OFF_CTRL, 32'h15);
    rd_reg(SCM_OFF_DATA);
    chk("rt ch2", 32'ha5a5, rv);
    wr_reg(SCM_OFF_CTRL, 32'h14);
    rd_reg(SCM_OFF_DATA);
    chk("rt off", 32'h0, rv);
    // six pre-arm readings wrap a four-place buffer
    wr_reg(SCM_OFF_PRE, 32'hffff_fffd);
    wr_reg(SCM_OFF_IMASK, 32'h1);
    wr_reg(SCM_OFF_CTRL, 32'h10d);
    u_conv.burst(6);
    u_conv.arm_ev();
    u_conv.burst(1);
    wait_irq();
    chk("done irq", 32'h1, {31'h0, irq});
    rd_reg(SCM_OFF_STATE);
    chk("state", 32'h403, rv & 32'h7c03);
    rd_reg(SCM_OFF_SEGSTAT);
    chk("segstat", {TOP[29:0], 2'b01}, rv);
    for (int i = 3; i < 7; i++) begin
      rd_reg(SCM_OFF_DATA);
      chk("both32", {16'h0200 + 16'(i), 16'h0100 + 16'(i)}, rv);
    end
    rd_reg(SCM_OFF_DATA);
    chk("drained", 32'h0, rv);
    wr_reg(SCM_OFF_ISTAT, 32'h7);
    @(negedge mclk_in);
    chk("cleared irq", 32'h0, {31'h0, irq});
    // second run ends by abort after two readings
    wr_reg(SCM_OFF_IMASK, 32'h4);
    wr_reg(SCM_OFF_CTRL, 32'h109);
    u_conv.burst(2);
    wr_reg(SCM_OFF_CTRL, 32'h209);
    wait_irq();
    chk("abort irq", 32'h1, {31'h0, irq});
    rd_reg(SCM_OFF_SEGSTAT);
    chk("segstat abort", {TOP[29:0] - 30'h1, 2'b10}, rv);
    rd_reg(SCM_OFF_DATA);
    chk("both ch1", 32'h0107, rv);
    rd_reg(SCM_OFF_DATA);
    chk("both ch2", 32'h0207, rv);
    wr_reg(SCM_OFF_IMASK, 32'h0);
    @(negedge mclk_in);
    chk("masked irq", 32'h0, {31'h0, irq});
    rd_reg(SCM_OFF_ISTAT);
    chk("abort status", 32'h4, rv & 32'h4);
    // two segments, each filled by three pre-arm and one post-arm reading
    wr_reg(SCM_OFF_ARM, 32'h2);
    wr_reg(SCM_OFF_IMASK, 32'h1);
    wr_reg(SCM_OFF_CTRL, 32'h101);
    for (int s = 0; s < 2; s++) begin
      u_conv.burst(3);
      u_conv.arm_ev();
      u_conv.burst(1);
    end
    wait_irq();
    chk("two seg irq", 32'h1, {31'h0, irq});
    rd_reg(SCM_OFF_STATE);
    chk("state two seg", 32'h1407, rv);
    rd_reg(SCM_OFF_SEGSTAT);
    chk("segstat seg0", {30'h0fc, 2'b01}, rv);
    wr_reg(SCM_OFF_SEGSEL, 32'h1);
    rd_reg(SCM_OFF_SEGSTAT);
    chk("segstat seg1", {TOP[29:0] - 30'h3, 2'b01}, rv);
    for (int i = 9; i < 17; i++) begin
      rd_reg(SCM_OFF_DATA);
      chk("two seg ch1", {16'h0, 16'h0100 + 16'(i)}, rv);
    end
    // a full-segment buffer only fits while no nv space is reserved
    wr_reg(SCM_OFF_TRIG, 32'h100);
    rd_reg(SCM_OFF_STATE);
    chk("fits", 32'h0, rv & 32'h800);
    wr_reg(SCM_OFF_CTRL, 32'h2);
    rd_reg(SCM_OFF_STATE);
    chk("nv no fit", 32'h800, rv & 32'h800);
    // reset after the finished run brings every register back to its default
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    foreach (rows[i]) begin
      rd_reg(rows[i][39:32]);
      chk("mid reset read", rows[i][31:0], rv);
    end
    summarize();
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    summarize();
  end
endmodule : tb_segmented_capture_memory
